// ===== pbvt_pkg.sv
package pbvt_pkg;

  // ==========================================================================
  // Tag identifiers and sizes.
  // ==========================================================================
  localparam logic [15:0] ETYPE_CTAG      = 16'h8100;
  localparam logic [15:0] ETYPE_STAG      = 16'h88a8;
  localparam logic [15:0] RST_SERVICE_TPID = 16'h88a8;
  localparam logic [13:0] SINGLE_TAG_EXTRA = 14'h0004;
  localparam logic [13:0] DOUBLE_TAG_EXTRA = 14'h0008;
  localparam logic [13:0] RST_MAX_LEN      = 14'h05ee;
  localparam logic [13:0] ACCESS_MAX_TOTAL = 14'h05f2;
  localparam int          NUM_VLANS        = 4096;
  localparam int          NUM_PORTS        = 8;

  // ==========================================================================
  // Egress tagging modes and table commands.
  // ==========================================================================
  localparam logic [1:0] EGR_UNTAG_ALL  = 2'h0;
  localparam logic [1:0] EGR_UNTAG_PORT_DEFAULT_VID = 2'h1;
  localparam logic [1:0] EGR_UNTAG_PRIO = 2'h2;
  localparam logic [1:0] EGR_TAG_ALL    = 2'h3;
  localparam logic [1:0] CMD_IDLE  = 2'h0;
  localparam logic [1:0] CMD_READ  = 2'h1;
  localparam logic [1:0] CMD_WRITE = 2'h2;
  localparam logic [1:0] CMD_INIT  = 2'h3;

  // Per-VLAN table entry.
  typedef struct packed {
    logic [NUM_PORTS-1:0] port_mask;
    logic                 vlan_no_learn;
  } pbvt_entry_type;

  localparam pbvt_entry_type RST_ENTRY = '{port_mask: 8'hff, vlan_no_learn: 1'b0};

  // One VLAN tag as parsed.
  typedef struct packed {
    logic        present;
    logic        is_service;
    logic [2:0]  pcp;
    logic        dei;
    logic [11:0] vid;
  } pbvt_tag_type;

  // Per-port configuration.
  typedef struct packed {
    logic [15:0] service_tpid_value;
    logic        discard_untagged;
    logic        discard_service_tagged;
    logic        discard_prio_service_tagged;
    logic        tag_aware_classify;
    logic [1:0]  tag_pop_count;
    logic        untagged_tag_kind;
    logic        classify_by_inner;
    logic        port_drop_eligible;
    logic [2:0]  port_priority_code;
    logic [11:0] port_vlan_id;
    logic        len_allow;
    logic [13:0] max_frame_length;
    logic [1:0]  egress_tag_mode;
    logic        customer_access;
  } pbvt_cfg_type;

  // Frame header as seen by the block.
  typedef struct packed {
    logic [15:0] etype0;
    logic [15:0] tci0;
    logic [15:0] etype1;
    logic [15:0] tci1;
    logic [13:0] length;
    logic [2:0]  src_port;
  } pbvt_hdr_type;

  // Classification and rewrite result.
  typedef struct packed {
    logic                 discard;
    logic                 learn;
    logic [11:0]          vid;
    logic [2:0]           pcp;
    logic                 dei;
    logic [1:0]           pop;
    logic                 push;
    logic [15:0]          push_tpid;
    logic                 egress_untag;
    logic [NUM_PORTS-1:0] fwd_mask;
  } pbvt_res_type;

endpackage

// ===== pbvt_top.sv
module pbvt_top (
  input  wire logic                    i_clk,
  input  wire logic                    i_resetn,
  input  wire pbvt_pkg::pbvt_cfg_type  i_cfg,
  input  wire logic                    i_hdr_valid,
  input  wire pbvt_pkg::pbvt_hdr_type  i_hdr,
  input  wire logic                    i_xlate_ing_en,
  input  wire logic [11:0]             i_xlate_ing_vid,
  input  wire logic                    i_xlate_egr_en,
  input  wire logic [11:0]             i_xlate_egr_vid,
  input  wire logic [11:0]             i_vlan_table_index,
  input  wire logic [1:0]              i_vlan_table_command,
  input  wire pbvt_pkg::pbvt_entry_type i_vlan_table_wdata,
  output logic                         o_res_valid,
  output pbvt_pkg::pbvt_res_type       o_res,
  output logic                         o_cmd_busy,
  output pbvt_pkg::pbvt_entry_type     o_vlan_table_rdata
);

  // ==========================================================================
  // Overview.
  // ==========================================================================
  // A header is taken in one cycle and its result stands two edges later.
  // Stage 1 parses up to two tags, applies the frame type and length checks
  // and classifies the VLAN. Stage 2 looks the VLAN up in the table and
  // decides forwarding, learning and the tag rewrite. Configuration is read
  // live in both stages, so software changes it only between frames. A new
  // header may follow in the very next cycle, and nothing stalls the flow.

  // ==========================================================================
  // Helpers.
  // ==========================================================================
  // Recognise a tag; the caller's TPID is the port's programmable value.
  // A programmable value equal to the customer type makes every customer
  // tag look like a service tag, so software must keep the two apart.
  function automatic pbvt_pkg::pbvt_tag_type parse_tag(input logic [15:0] et,
                                                        input logic [15:0] tci,
                                                        input logic [15:0] tpid);
    pbvt_pkg::pbvt_tag_type t;
    t = '0;
    t.present    = (et == pbvt_pkg::ETYPE_CTAG) || (et == pbvt_pkg::ETYPE_STAG) || (et == tpid);
    t.is_service = (et == pbvt_pkg::ETYPE_STAG) || (et == tpid);
    t.pcp        = tci[15:13];
    t.dei        = tci[12];
    t.vid        = tci[11:0];
    return t;
  endfunction

  // A tag whose VID is zero only carries priority and never names a VLAN.
  function automatic logic is_prio_vid(input logic [11:0] vid);
    return vid == 12'h000;
  endfunction

  // The init sweep ends on the last entry of the table.
  function automatic logic sweep_last(input logic [11:0] idx);
    return idx == 12'(pbvt_pkg::NUM_VLANS - 1);
  endfunction

  // Extra bytes allowed for the tags a frame carries, when allowance is on.
  function automatic logic [13:0] tag_allowance(input logic [1:0] depth);
    logic [13:0] extra;
    case (depth)
      2'h1:    extra = pbvt_pkg::SINGLE_TAG_EXTRA;
      2'h2:    extra = pbvt_pkg::DOUBLE_TAG_EXTRA;
      default: extra = 14'h0000;
    endcase
    return extra;
  endfunction

  // ==========================================================================
  // VLAN table with indirect access.
  // ==========================================================================
  // Index, write data and command are taken on the same edge, so software
  // sets the index no later than the command. Every command is ignored while
  // the init sweep runs; the busy flag, the only sign of that, stays low in the first cycle of a sweep started by command. The table
  // has no reset of its own: the sweep fills it after every reset.
  pbvt_pkg::pbvt_entry_type vlan_table [pbvt_pkg::NUM_VLANS];
  logic [11:0]              init_idx_ff;
  logic                     init_run_ff;

  // Table writes; the sweep takes precedence over a write command.
  // indexed command access
  always_ff @(posedge i_clk) begin
    if (init_run_ff) begin
      vlan_table[init_idx_ff] <= pbvt_pkg::RST_ENTRY;
    end else if (i_vlan_table_command == pbvt_pkg::CMD_WRITE) begin
      vlan_table[i_vlan_table_index] <= i_vlan_table_wdata;
    end
  end

  // Table initialisation sweeps all entries after reset or on command.
  // One entry is written per clock, so a sweep lasts one cycle per VLAN.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      init_run_ff <= 1'b1;
      init_idx_ff <= 12'h000;
    end else if (init_run_ff) begin
      init_idx_ff <= init_idx_ff + 12'h001;
      if (sweep_last(init_idx_ff)) begin
        init_run_ff <= 1'b0;
      end
    end else if (i_vlan_table_command == pbvt_pkg::CMD_INIT) begin
      init_run_ff <= 1'b1;
      init_idx_ff <= 12'h000;
    end
  end

  // Busy flag and read-back of the indexed entry.
  // Busy drops on the edge that writes the last entry, so a command issued
  // on the next edge already finds the sweep finished. Read data follows the
  // read command by one edge and then holds until the next read.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_cmd_busy         <= 1'b1;
      o_vlan_table_rdata <= '0;
    end else begin
      o_cmd_busy <= init_run_ff && !sweep_last(init_idx_ff);
      if (!init_run_ff && i_vlan_table_command == pbvt_pkg::CMD_READ) begin
        o_vlan_table_rdata <= vlan_table[i_vlan_table_index];
      end
    end
  end

  // ==========================================================================
  // Stage 1: parse, discard checks and classification.
  // ==========================================================================
  // The header is taken on the edge that sees the valid flag and only its source port, tag depth and outer
  // priority flag are held afterwards, so all other decisions that need it are made in this stage. The
  // inner tag only counts when the outer word is itself a tag; an ordinary
  // type in the outer word ends the tag stack.
  pbvt_pkg::pbvt_tag_type outer_tag;
  pbvt_pkg::pbvt_tag_type inner_tag;
  logic [1:0]             tag_depth;
  logic [13:0]            len_limit;
  logic                   nxt_discard;
  logic [11:0]            nxt_vid;
  logic [2:0]             nxt_pcp;
  logic                   nxt_dei;

  always_comb begin
    outer_tag = parse_tag(i_hdr.etype0, i_hdr.tci0, i_cfg.service_tpid_value);
    inner_tag = parse_tag(i_hdr.etype1, i_hdr.tci1, i_cfg.service_tpid_value);
    inner_tag.present = inner_tag.present && outer_tag.present;
    tag_depth = {1'b0, outer_tag.present} + {1'b0, inner_tag.present};
  end

  // Length limit grows with the number of tags carried. The access floor is
  // applied after the allowance, so a customer port never drops a frame that
  // fits the access size, whatever maximum is configured.
  always_comb begin
    len_limit = i_cfg.max_frame_length;
    if (i_cfg.len_allow) begin
      len_limit = i_cfg.max_frame_length + tag_allowance(tag_depth);
    end
    if (i_cfg.customer_access && len_limit < pbvt_pkg::ACCESS_MAX_TOTAL) begin
      len_limit = pbvt_pkg::ACCESS_MAX_TOTAL;
    end
  end

  // Acceptable frame type and length checks.
  // Any check may discard; the later stage then suppresses forwarding,
  // learning and every rewrite for that frame.
  always_comb begin
    nxt_discard = i_hdr.length > len_limit;
    if (!outer_tag.present && i_cfg.discard_untagged) begin
      nxt_discard = 1'b1;
    end
    if (outer_tag.present && outer_tag.is_service && i_cfg.discard_service_tagged) begin
      nxt_discard = 1'b1;
    end
    if (outer_tag.present && outer_tag.is_service && is_prio_vid(outer_tag.vid) &&
        i_cfg.discard_prio_service_tagged) begin
      nxt_discard = 1'b1;
    end
  end

  // VLAN classification from tag or port values.
  // A priority tag keeps the port VID but still supplies its priority and
  // drop eligibility. Ingress translation overrides the VID last.
  always_comb begin
    nxt_vid = i_cfg.port_vlan_id;
    nxt_pcp = i_cfg.port_priority_code;
    nxt_dei = i_cfg.port_drop_eligible;
    if (i_cfg.tag_aware_classify && outer_tag.present) begin
      if (i_cfg.classify_by_inner && inner_tag.present) begin
        nxt_pcp = inner_tag.pcp;
        nxt_dei = inner_tag.dei;
        if (!is_prio_vid(inner_tag.vid)) begin
          nxt_vid = inner_tag.vid;
        end
      end else begin
        nxt_pcp = outer_tag.pcp;
        nxt_dei = outer_tag.dei;
        if (!is_prio_vid(outer_tag.vid)) begin
          nxt_vid = outer_tag.vid;
        end
      end
    end
    if (i_xlate_ing_en) begin
      nxt_vid = i_xlate_ing_vid;
    end
  end

  logic                   s1_valid_ff;
  logic                   s1_discard_ff;
  logic [11:0]            s1_vid_ff;
  logic [2:0]             s1_pcp_ff;
  logic                   s1_dei_ff;
  logic [1:0]             s1_depth_ff;
  logic                   s1_outer_prio_ff;
  logic [2:0]             src_port_ff;

  // Stage 1 registers. Values are captured every cycle; the valid bit alone
  // marks the cycles that carry a frame.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s1_valid_ff      <= 1'b0;
      s1_discard_ff    <= 1'b0;
      s1_vid_ff        <= 12'h000;
      s1_pcp_ff        <= 3'h0;
      s1_dei_ff        <= 1'b0;
      s1_depth_ff      <= 2'h0;
      s1_outer_prio_ff <= 1'b0;
    end else begin
      s1_valid_ff      <= i_hdr_valid;
      s1_discard_ff    <= nxt_discard;
      s1_vid_ff        <= nxt_vid;
      s1_pcp_ff        <= nxt_pcp;
      s1_dei_ff        <= nxt_dei;
      s1_depth_ff      <= tag_depth;
      s1_outer_prio_ff <= outer_tag.present && is_prio_vid(outer_tag.vid);
    end
  end

  // ==========================================================================
  // Stage 2: table lookup, rewrite decision and result.
  // ==========================================================================
  // The table is looked up with the classified VID one edge after the header.
  // Egress translation is taken in this cycle too and replaces the VID in the
  // result. Pop is capped at the tags the frame really carries, and a tag is
  // pushed when none is left or the port ignores incoming tags. The egress
  // untag bit tells the rewriter to strip only the outer tag; an inner
  // customer tag stays in place unless the pop count removes it.
  pbvt_pkg::pbvt_entry_type entry;
  pbvt_pkg::pbvt_res_type   nxt_res;
  logic [1:0]               pop_n;

  always_comb begin
    entry   = vlan_table[s1_vid_ff];
    nxt_res = '0;
    pop_n = (i_cfg.tag_pop_count > s1_depth_ff) ? s1_depth_ff : i_cfg.tag_pop_count;
    nxt_res.vid     = i_xlate_egr_en ? i_xlate_egr_vid : s1_vid_ff;
    nxt_res.pcp     = s1_pcp_ff;
    nxt_res.dei     = s1_dei_ff;
    nxt_res.discard = s1_discard_ff;
    if (!s1_discard_ff) begin
      nxt_res.pop = pop_n;
      nxt_res.learn = !entry.vlan_no_learn;
      nxt_res.fwd_mask = entry.port_mask & ~(pbvt_pkg::NUM_PORTS'(1) << src_port_ff);
      nxt_res.push = (s1_depth_ff == pop_n) || !i_cfg.tag_aware_classify;
      nxt_res.push_tpid = i_cfg.untagged_tag_kind ? i_cfg.service_tpid_value : pbvt_pkg::ETYPE_CTAG;
      case (i_cfg.egress_tag_mode)
        pbvt_pkg::EGR_UNTAG_ALL:  nxt_res.egress_untag = 1'b1;
        pbvt_pkg::EGR_UNTAG_PORT_DEFAULT_VID: nxt_res.egress_untag = (nxt_res.vid == i_cfg.port_vlan_id);
        pbvt_pkg::EGR_UNTAG_PRIO: nxt_res.egress_untag = s1_outer_prio_ff;
        default:                  nxt_res.egress_untag = 1'b0;
      endcase
    end
  end

  // Source port carried alongside stage 1; it is masked out of the flood set
  // so a frame never returns to the port it came from.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      src_port_ff <= 3'h0;
    end else begin
      src_port_ff <= i_hdr.src_port;
    end
  end

  // Result registers. The result word follows stage 2 every cycle and is only
  // meaningful in the cycle in which the valid bit stands.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_res_valid <= 1'b0;
      o_res       <= '0;
    end else begin
      o_res_valid <= s1_valid_ff;
      o_res       <= nxt_res;
    end
  end

endmodule

// ===== pbvt_monitor.sv
// ============================================================================
// Port-level checker for the tag classifier.
// ============================================================================
module pbvt_monitor (
  input wire logic                   i_clk,
  input wire logic                   i_resetn,
  input wire pbvt_pkg::pbvt_cfg_type i_cfg,
  input wire logic                   i_hdr_valid,
  input wire pbvt_pkg::pbvt_hdr_type i_hdr,
  input wire logic                   i_xlate_ing_en,
  input wire logic                   i_xlate_egr_en,
  input wire logic                   o_res_valid,
  input wire pbvt_pkg::pbvt_res_type o_res,
  input wire logic                   o_cmd_busy
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  logic        svc;
  logic        tagd;
  logic [12:0] busy_ff;

  // Classifies the outer header word as a service or any tag.
  assign svc  = (i_hdr.etype0 == pbvt_pkg::ETYPE_STAG) || (i_hdr.etype0 == i_cfg.service_tpid_value);
  assign tagd = svc || (i_hdr.etype0 == pbvt_pkg::ETYPE_CTAG);

  // Measures each table sweep so a stuck busy flag is caught.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      busy_ff <= 13'h0000;
    end else if (o_cmd_busy) begin
      busy_ff <= busy_ff + 13'h0001;
    end else begin
      busy_ff <= 13'h0000;
    end
  end

  a_result_latency: assert property (i_hdr_valid |-> ##2 o_res_valid)
    else $error("result missing two cycles after header");
  a_result_cause: assert property (o_res_valid |-> $past(i_hdr_valid, 2))
    else $error("result without a header");
  a_discard_inert: assert property (o_res_valid && o_res.discard |->
    o_res.fwd_mask == '0 && !o_res.push && o_res.pop == 2'h0 && !o_res.learn)
    else $error("discarded frame still forwarded or rewritten");
  a_untagged_drop: assert property (i_hdr_valid && i_cfg.discard_untagged && !tagd |->
    ##2 o_res.discard)
    else $error("untagged frame not dropped");
  a_service_drop: assert property (i_hdr_valid && i_cfg.discard_service_tagged && svc |->
    ##2 o_res.discard)
    else $error("service tagged frame not dropped");
  a_prio_drop: assert property (i_hdr_valid && i_cfg.discard_prio_service_tagged && svc &&
    i_hdr.tci0[11:0] == 12'h000 |-> ##2 o_res.discard)
    else $error("priority service tagged frame not dropped");
  a_port_vlan: assert property (i_hdr_valid && !i_cfg.tag_aware_classify && !i_xlate_ing_en |->
    ##2 (o_res.discard || $past(i_xlate_egr_en) || o_res.vid == $past(i_cfg.port_vlan_id, 2)))
    else $error("unaware port did not use its own vlan");
  a_push_tpid: assert property (o_res_valid && o_res.push |-> o_res.push_tpid ==
    ($past(i_cfg.untagged_tag_kind) ? $past(i_cfg.service_tpid_value) : pbvt_pkg::ETYPE_CTAG))
    else $error("pushed tag has an unknown identifier");
  a_sweep_bound: assert property (busy_ff <= 13'h1008)
    else $error("table sweep runs too long");

  // Main scenarios reached by the bench.
  c_discard: cover property (o_res_valid && o_res.discard);
  c_push: cover property (o_res_valid && o_res.push);
  c_sweep_end: cover property ($fell(o_cmd_busy));
endmodule

bind pbvt_top pbvt_monitor u_mon (.i_clk(i_clk), .i_resetn(i_resetn), .i_cfg(i_cfg), .i_hdr_valid(i_hdr_valid),
  .i_hdr(i_hdr), .i_xlate_ing_en(i_xlate_ing_en), .i_xlate_egr_en(i_xlate_egr_en),
  .o_res_valid(o_res_valid), .o_res(o_res),
  .o_cmd_busy(o_cmd_busy));

// ===== pbvt_link_partner.sv
// ============================================================================
// Link partner that presents received frame headers.
// ============================================================================
module pbvt_link_partner (
  input  wire logic             i_clk,
  output pbvt_pkg::pbvt_hdr_type o_hdr,
  output logic                  o_hdr_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero.
  initial begin
    o_hdr = '0;
    o_hdr_valid = 1'b0;
  end

  // Holds one header for a single cycle, then scrambles the idle bus.
  task automatic send(input pbvt_pkg::pbvt_hdr_type hdr);
    @(negedge i_clk);
    o_hdr = hdr;
    o_hdr_valid = 1'b1;
    @(negedge i_clk);
    o_hdr_valid = 1'b0;
    o_hdr = ~hdr;
  endtask
endmodule

// ===== pbvt_top_tb.sv
// ============================================================================
// Self-checking bench for the tag classifier.
// ============================================================================
module pbvt_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                     clk, resetn, xi_en, xe_en, hv, rv, busy;
  logic [11:0]              xi_vid, xe_vid, idx;
  logic [1:0]               cmd;
  pbvt_pkg::pbvt_cfg_type   cfg;
  pbvt_pkg::pbvt_hdr_type   hdr;
  pbvt_pkg::pbvt_entry_type wd, rd;
  pbvt_pkg::pbvt_res_type   res;
  int                       n_errors, checked, cycles;

  pbvt_link_partner LP (.i_clk(clk), .o_hdr(hdr), .o_hdr_valid(hv));
  pbvt_top DUT (.i_clk(clk), .i_resetn(resetn), .i_cfg(cfg), .i_hdr_valid(hv), .i_hdr(hdr),
    .i_xlate_ing_en(xi_en), .i_xlate_ing_vid(xi_vid), .i_xlate_egr_en(xe_en), .i_xlate_egr_vid(xe_vid),
    .i_vlan_table_index(idx), .i_vlan_table_command(cmd), .i_vlan_table_wdata(wd),
    .o_res_valid(rv), .o_res(res), .o_cmd_busy(busy), .o_vlan_table_rdata(rd));

  // Clock and hang guard.
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  // ==========================================================================
  // Shared tasks.
  // ==========================================================================
  task automatic wrap_up();
    if (n_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic pbvt_pkg::pbvt_cfg_type base();
    base = '0;
    base.service_tpid_value = pbvt_pkg::ETYPE_STAG;
    base.port_vlan_id = 12'h00a;
    base.port_priority_code = 3'h5;
    base.port_drop_eligible = 1'b1;
    base.max_frame_length = 14'h0064;
    base.len_allow = 1'b1;
    base.egress_tag_mode = pbvt_pkg::EGR_TAG_ALL;
  endfunction

  task automatic frame(input logic [15:0] e0, t0, e1, t1, input logic [13:0] len);
    LP.send('{e0, t0, e1, t1, len, 3'h2});
    @(negedge clk);
    chk(rv, 1'b1);
  endtask

  task automatic table_cmd(input logic [1:0] c, input logic [11:0] i, input pbvt_pkg::pbvt_entry_type d);
    @(negedge clk);
    idx = i;
    wd = d;
    cmd = c;
    @(negedge clk);
    cmd = pbvt_pkg::CMD_IDLE;
    @(negedge clk);
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 5000) begin
      @(negedge clk);
      k++;
    end
    chk(busy, 1'b0);
  endtask

  // ==========================================================================
  // Scenarios.
  // ==========================================================================
  task automatic s_port();
    cfg = base();
    frame(16'h8100, 16'h0076, 16'h0800, 16'h0000, 14'h0040);
    chk({res.vid, res.pcp, res.dei}, {12'h00a, 3'h5, 1'b1});
    chk({res.push, res.push_tpid}, {1'b1, pbvt_pkg::ETYPE_CTAG});
    cfg.untagged_tag_kind = 1'b1;
    frame(16'h0800, 16'h0000, 16'h0000, 16'h0000, 14'h0040);
    chk({res.push, res.push_tpid, res.vid}, {1'b1, pbvt_pkg::ETYPE_STAG, 12'h00a});
  endtask

  task automatic s_drops();
    cfg = base();
    cfg.discard_untagged = 1'b1;
    frame(16'h0800, 16'h0000, 16'h0000, 16'h0000, 14'h0040);
    chk({res.discard, res.fwd_mask, res.learn}, 10'h200);
    frame(16'h8100, 16'h0003, 16'h0800, 16'h0000, 14'h0040);
    chk(res.discard, 1'b0);
    cfg = base();
    cfg.service_tpid_value = 16'h9100;
    cfg.discard_service_tagged = 1'b1;
    frame(16'h9100, 16'h0003, 16'h0800, 16'h0000, 14'h0040);
    chk(res.discard, 1'b1);
    frame(16'h88a8, 16'h0003, 16'h0800, 16'h0000, 14'h0040);
    chk(res.discard, 1'b1);
    cfg = base();
    cfg.discard_prio_service_tagged = 1'b1;
    frame(16'h88a8, 16'ha000, 16'h0800, 16'h0000, 14'h0040);
    chk(res.discard, 1'b1);
    frame(16'h88a8, 16'h0003, 16'h0800, 16'h0000, 14'h0040);
    chk(res.discard, 1'b0);
  endtask

  task automatic s_aware();
    cfg = base();
    cfg.tag_aware_classify = 1'b1;
    cfg.tag_pop_count = 2'h1;
    frame(16'h88a8, 16'h0001, 16'h8100, 16'h0076, 14'h0040);
    chk({res.vid, res.pop}, {12'h001, 2'h1});
    cfg.classify_by_inner = 1'b1;
    cfg.tag_pop_count = 2'h2;
    frame(16'h88a8, 16'h0001, 16'h8100, 16'h0076, 14'h0040);
    chk({res.vid, res.pop}, {12'h076, 2'h2});
    cfg = base();
    cfg.tag_aware_classify = 1'b1;
    cfg.service_tpid_value = 16'h9100;
    frame(16'h9100, 16'h0123, 16'h0800, 16'h0000, 14'h0040);
    chk(res.vid, 12'h123);
    xi_en = 1'b1;
    xi_vid = 12'h0ab;
    frame(16'h8100, 16'h0064, 16'h0800, 16'h0000, 14'h0040);
    chk(res.vid, 12'h0ab);
    xe_en = 1'b1;
    xe_vid = 12'h0cd;
    frame(16'h8100, 16'h0064, 16'h0800, 16'h0000, 14'h0040);
    chk(res.vid, 12'h0cd);
    xi_en = 1'b0;
    xe_en = 1'b0;
  endtask

  task automatic s_len();
    cfg = base();
    frame(16'h0800, 16'h0000, 16'h0000, 16'h0000, 14'h0065);
    chk(res.discard, 1'b1);
    frame(16'h8100, 16'h0003, 16'h0800, 16'h0000, 14'h0068);
    chk(res.discard, 1'b0);
    frame(16'h8100, 16'h0003, 16'h0800, 16'h0000, 14'h0069);
    chk(res.discard, 1'b1);
    frame(16'h88a8, 16'h0003, 16'h8100, 16'h0003, 14'h006c);
    chk(res.discard, 1'b0);
    cfg.len_allow = 1'b0;
    cfg.customer_access = 1'b1;
    frame(16'h0800, 16'h0000, 16'h0000, 16'h0000, 14'h05f2);
    chk(res.discard, 1'b0);
    frame(16'h0800, 16'h0000, 16'h0000, 16'h0000, 14'h05f3);
    chk(res.discard, 1'b1);
  endtask

  task automatic s_egress();
    cfg = base();
    for (int m = 0; m < 4; m++) begin
      cfg.egress_tag_mode = 2'(m);
      frame(16'h0800, 16'h0000, 16'h0000, 16'h0000, 14'h0040);
      chk(res.egress_untag, 4'b0011 >> m & 1);
    end
    cfg.tag_aware_classify = 1'b1;
    cfg.egress_tag_mode = pbvt_pkg::EGR_UNTAG_PRIO;
    frame(16'h8100, 16'h2000, 16'h0800, 16'h0000, 14'h0040);
    chk(res.egress_untag, 1'b1);
    cfg.egress_tag_mode = pbvt_pkg::EGR_UNTAG_ALL;
    frame(16'h88a8, 16'h0001, 16'h8100, 16'h0076, 14'h0040);
    chk({res.egress_untag, res.pop}, {1'b1, 2'h0});
  endtask

  task automatic s_table();
    table_cmd(pbvt_pkg::CMD_WRITE, 12'h007, '{8'h03, 1'b1});
    table_cmd(pbvt_pkg::CMD_READ, 12'h007, '0);
    chk(rd, {8'h03, 1'b1});
    cfg = base();
    cfg.tag_aware_classify = 1'b1;
    frame(16'h8100, 16'h0007, 16'h0800, 16'h0000, 14'h0040);
    chk({res.learn, res.fwd_mask}, 9'h003);
    frame(16'h8100, 16'h0008, 16'h0800, 16'h0000, 14'h0040);
    chk({res.learn, res.fwd_mask}, 9'h1fb);
    table_cmd(pbvt_pkg::CMD_INIT, 12'h000, '0);
    table_cmd(pbvt_pkg::CMD_WRITE, 12'h001, '{8'h01, 1'b1});
    wait_idle();
    table_cmd(pbvt_pkg::CMD_READ, 12'h007, '0);
    chk(rd, pbvt_pkg::RST_ENTRY);
    table_cmd(pbvt_pkg::CMD_READ, 12'h001, '0);
    chk(rd, pbvt_pkg::RST_ENTRY);
  endtask

  // Reset, then run every scenario.
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    cfg = base();
    cmd = pbvt_pkg::CMD_IDLE;
    idx = '0;
    wd = '0;
    xi_en = 1'b0;
    xi_vid = '0;
    xe_en = 1'b0;
    xe_vid = '0;
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    wait_idle();
    s_port();
    s_drops();
    s_aware();
    s_len();
    s_egress();
    s_table();
    wrap_up();
  end
endmodule
